// *** rtl/rx_pkg.sv ***
package rx_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_CMD  = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;
  localparam logic [7:0] OFF_IRQS = 8'h10;
  localparam logic [7:0] OFF_IRQM = 8'h14;
  localparam logic [7:0] OFF_PHI  = 8'h18;
  localparam logic [7:0] OFF_PLO  = 8'h1C;
  localparam logic [7:0] OFF_CNT  = 8'h20;

  // mode word fields and reset value
  localparam int MB_ERRMODE = 0;
  localparam int MB_WDEN    = 1;
  localparam int MB_FULLSRC = 2;
  localparam int MB_FLOW    = 3;
  localparam int MB_DEPTH16 = 4;
  localparam int MODE_W     = 5;
  localparam logic [4:0] MODE_RST = 5'h00;

  // interrupt status / mask fields
  localparam int IB_RX  = 0;
  localparam int IB_WD  = 1;
  localparam int IB_BRK = 2;
  localparam int IB_CTR = 3;
  localparam int IRQ_W  = 4;
  localparam logic [3:0] IRQM_RST = 4'h0;

  // command codes, taken from write data bits 7:4
  localparam logic [3:0] CMD_RX_EN    = 4'h1;
  localparam logic [3:0] CMD_RX_DIS   = 4'h2;
  localparam logic [3:0] CMD_RX_RST   = 4'h3;
  localparam logic [3:0] CMD_ERR_RST  = 4'h4;
  localparam logic [3:0] CMD_BRK_RST  = 4'h5;
  localparam logic [3:0] CMD_CT_START = 4'h6;
  localparam logic [3:0] CMD_CT_STOP  = 4'h7;
  localparam logic [3:0] CMD_TO_ON    = 4'hA;
  localparam logic [3:0] CMD_TO_OFF   = 4'hC;

  // queue geometry: data byte plus parity, framing and break bits
  localparam int ENT_W     = 11;
  localparam int E_PERR    = 8;
  localparam int DEPTH_MAX = 16;
  localparam int PTR_W     = 4;
  localparam int CNT_W     = 5;
  localparam logic [4:0] DEPTH_LO = 5'h08;
  localparam logic [4:0] DEPTH_HI = 5'h10;

  // watchdog length in bit times
  localparam logic [6:0] WD_BIT_TIMES = 7'h40;
  localparam int WD_W = 7;

  // counter/timer
  localparam int CT_W = 16;
  localparam logic [15:0] CT_RST = 16'h0000;
endpackage

// *** rtl/rx_queue.sv ***
`timescale 1ns/1ps
module rx_queue (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // control
  input  wire logic                       clr,
  input  wire logic                       depth16,
  // write side
  input  wire logic                       push,
  input  wire logic [rx_pkg::ENT_W-1:0]   din,
  // read side
  input  wire logic                       pop,
  output logic      [rx_pkg::ENT_W-1:0]   dout,
  // state
  output logic                            empty,
  output logic                            full,
  output logic      [rx_pkg::CNT_W-1:0]   count
);
  logic [rx_pkg::ENT_W-1:0] mem_r [rx_pkg::DEPTH_MAX];
  logic [rx_pkg::PTR_W-1:0] wr_ptr_r;
  logic [rx_pkg::PTR_W-1:0] rd_ptr_r;
  logic [rx_pkg::CNT_W-1:0] cnt_r;
  logic [rx_pkg::CNT_W-1:0] cap;
  logic                     do_push;
  logic                     do_pop;
  logic [rx_pkg::PTR_W-1:0] wr_nxt;
  logic [rx_pkg::PTR_W-1:0] rd_nxt;

  // capacity and pointer wrap follow the selected depth
  assign cap     = depth16 ? rx_pkg::DEPTH_HI : rx_pkg::DEPTH_LO;
  assign full    = cnt_r == cap;
  assign empty   = cnt_r == '0;
  assign count   = cnt_r;
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;
  assign wr_nxt  = depth16 ? wr_ptr_r + 4'h1 : {1'b0, wr_ptr_r[2:0] + 3'h1};
  assign rd_nxt  = depth16 ? rd_ptr_r + 4'h1 : {1'b0, rd_ptr_r[2:0] + 3'h1};
  assign dout    = mem_r[rd_ptr_r];

  // storage, one flop row per entry
  for (genvar i = 0; i < rx_pkg::DEPTH_MAX; i++) begin : g_ent
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        mem_r[i] <= '0;
      else if (do_push && wr_ptr_r == rx_pkg::PTR_W'(i))
        mem_r[i] <= din;
    end
  end

  // pointers and fill count; clear realigns both pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else if (clr) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (do_push) wr_ptr_r <= wr_nxt;
      if (do_pop) rd_ptr_r <= rd_nxt;
      if (do_push && !do_pop) cnt_r <= cnt_r + 5'h01;
      else if (do_pop && !do_push) cnt_r <= cnt_r - 5'h01;
    end
  end
endmodule

// *** rtl/ct_timer.sv ***
`timescale 1ns/1ps
module ct_timer (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // timer clock enable and controls
  input  wire logic                     tick,
  input  wire logic                     load_run,
  input  wire logic                     stop,
  input  wire logic                     restart,
  input  wire logic [rx_pkg::CT_W-1:0]  preset,
  // state
  output logic      [rx_pkg::CT_W-1:0]  value,
  output logic                          running,
  output logic                          done
);
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_RUN    = 4'b0010,
    ST_STOP1  = 4'b0100,
    ST_RELOAD = 4'b1000
  } ct_state_t;

  ct_state_t               st_r;
  logic [rx_pkg::CT_W-1:0] cnt_r;
  logic                    done_r;

  assign value   = cnt_r;
  assign running = st_r == ST_RUN;
  assign done    = done_r;

  // restart halts at once, waits one timer clock, reloads on the next, then counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= ST_IDLE;
      cnt_r  <= rx_pkg::CT_RST;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (stop) begin
        st_r <= ST_IDLE;
      end else if (load_run) begin
        cnt_r <= preset;
        st_r  <= ST_RUN;
      end else if (restart) begin
        st_r <= ST_STOP1;
      end else if (tick) begin
        unique case (st_r)
          ST_IDLE: ;
          ST_RUN: begin
            if (cnt_r <= 16'h0001) begin
              cnt_r  <= '0;
              done_r <= 1'b1;
              st_r   <= ST_IDLE;
            end else begin
              cnt_r <= cnt_r - 16'h0001;
            end
          end
          ST_STOP1: st_r <= ST_RELOAD;
          ST_RELOAD: begin
            cnt_r <= preset;
            st_r  <= ST_RUN;
          end
        endcase
      end
    end
  end
endmodule

// *** rtl/uart_rx_fifo_timeout.sv ***
// Notes on behaviour
// - waiting flag while queue holds data; full flag when every slot used
// - mode bit picks waiting or full flag as receiver interrupt source
// - data read returns oldest entry, then pops it with its status
// - disabled receiver keeps flags, interrupts and watchdog alive
// - entries carry parity, framing, break; overrun and break change apart
// - error mode: head entry only, or OR of all heads since error reset
// - status read never touches the queue; only data read pops
// - char done on full queue held; next start bit loses it, sets overrun
// - flow control: rts high on start bit with full queue, low when freed
// - disabled receiver still readable, accepts no new characters
// - disable drops partial character, keeps queue; resume at next start
// - receiver reset clears holder, flags, status, pointers, rts, receiver irq sources; counter ready is kept
// - watchdog expires after 64 bit times; its irq gated by enable bit
// - watchdog restarts on push or pop, idle while queue empty
// - command code A enters time-out mode, code C leaves it
// - in time-out mode start and stop counter commands are ignored
// - each push stops timer at once, waits one clock, reloads and restarts next clock
// - count reaching zero sets counter ready; irq when mask bit set
// - a character after time-out clears counter ready and its irq
// - time-out on clears counter ready, timer idle until first push
// - break pushes an all-zero character with its break bit set
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module uart_rx_fifo_timeout (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // character sampler, same clock
  input  wire logic        start_det,
  input  wire logic        char_done,
  input  wire logic [7:0]  char_data,
  input  wire logic        char_perr,
  input  wire logic        char_ferr,
  input  wire logic        char_brk,
  input  wire logic        bit_tick,
  input  wire logic        ct_tick,
  // line and status outputs
  output logic             request_to_send_out_n,
  output logic             rx_char_waiting_flag,
  output logic             queue_full_flag,
  output logic             irq
);
  // register state
  logic [rx_pkg::MODE_W-1:0] mode_r;
  logic [rx_pkg::IRQ_W-1:0]  interrupt_mask_word;
  logic [7:0]                timer_preset_high;
  logic [7:0]                timer_preset_low;
  logic [31:0]               prdata_r;
  // receiver state
  logic                      rx_en_r;
  logic                      hold_v_r;
  logic [rx_pkg::ENT_W-1:0]  hold_r;
  logic                      overrun_error_bit;
  logic [2:0]                acc_r;
  logic                      break_change_status_bit;
  logic                      brk_last_r;
  logic                      rts_n_r;
  logic [rx_pkg::WD_W-1:0]   wd_cnt_r;
  logic                      wd_exp_r;
  logic                      to_mode_r;
  logic                      counter_ready_status_bit;

  // apb decode
  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire wr       = access & pwrite;
  wire rd       = access & ~pwrite;
  wire hit_mode = paddr == rx_pkg::OFF_MODE;
  wire hit_stat = paddr == rx_pkg::OFF_STAT;
  wire hit_cmd  = paddr == rx_pkg::OFF_CMD;
  wire hit_data = paddr == rx_pkg::OFF_DATA;
  wire hit_irqs = paddr == rx_pkg::OFF_IRQS;
  wire hit_irqm = paddr == rx_pkg::OFF_IRQM;
  wire hit_phi  = paddr == rx_pkg::OFF_PHI;
  wire hit_plo  = paddr == rx_pkg::OFF_PLO;
  wire hit_cnt  = paddr == rx_pkg::OFF_CNT;
  wire mapped   = hit_mode | hit_stat | hit_cmd | hit_data | hit_irqs
                | hit_irqm | hit_phi | hit_plo | hit_cnt;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_r;

  // command strobes
  wire       cmd_wr    = wr & hit_cmd;
  wire [3:0] cmd       = pwdata[7:4];
  wire       c_en      = cmd_wr & (cmd == rx_pkg::CMD_RX_EN);
  wire       c_dis     = cmd_wr & (cmd == rx_pkg::CMD_RX_DIS);
  wire       c_rst     = cmd_wr & (cmd == rx_pkg::CMD_RX_RST);
  wire       c_err     = cmd_wr & (cmd == rx_pkg::CMD_ERR_RST);
  wire       c_brk     = cmd_wr & (cmd == rx_pkg::CMD_BRK_RST);
  wire       c_start   = cmd_wr & (cmd == rx_pkg::CMD_CT_START);
  wire       c_stop    = cmd_wr & (cmd == rx_pkg::CMD_CT_STOP);
  wire       c_to_on   = cmd_wr & (cmd == rx_pkg::CMD_TO_ON);
  wire       c_to_off  = cmd_wr & (cmd == rx_pkg::CMD_TO_OFF);

  // mode fields
  wire blk_mode = mode_r[rx_pkg::MB_ERRMODE];
  wire watchdog_irq_enable_bit = mode_r[rx_pkg::MB_WDEN];
  wire full_src = mode_r[rx_pkg::MB_FULLSRC];
  wire flow_en  = mode_r[rx_pkg::MB_FLOW];
  wire depth16  = mode_r[rx_pkg::MB_DEPTH16];

  // queue interface
  logic [rx_pkg::ENT_W-1:0] head;
  logic [rx_pkg::ENT_W-1:0] q_din;
  logic                     q_empty;
  logic                     q_full;
  logic [rx_pkg::CNT_W-1:0] q_count;
  wire [rx_pkg::ENT_W-1:0] new_ent = {char_brk, char_ferr, char_perr,
                                      char_brk ? 8'h00 : char_data};
  wire new_ok    = rx_en_r & char_done;
  wire push_hold = hold_v_r & ~q_full;
  wire push_new  = new_ok & ~q_full & ~hold_v_r;
  wire push      = push_hold | push_new;
  wire pop       = rd & hit_data & ~q_empty;
  assign q_din   = push_hold ? hold_r : new_ent;

  rx_queue u_queue (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (c_rst),
    .depth16 (depth16),
    .push    (push),
    .din     (q_din),
    .pop     (pop),
    .dout    (head),
    .empty   (q_empty),
    .full    (q_full),
    .count   (q_count)
  );

  // counter/timer, driven by commands or by the received stream
  logic [rx_pkg::CT_W-1:0] ct_value;
  logic                    ct_running;
  logic                    ct_done;
  wire ct_load    = c_start & ~to_mode_r;
  wire ct_stop    = (c_stop & ~to_mode_r) | c_to_on;
  wire ct_restart = to_mode_r & push;

  ct_timer u_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (ct_tick),
    .load_run (ct_load),
    .stop     (ct_stop),
    .restart  (ct_restart),
    .preset   ({timer_preset_high, timer_preset_low}),
    .value    (ct_value),
    .running  (ct_running),
    .done     (ct_done)
  );

  // status views
  wire [2:0] head_err  = q_empty ? 3'h0 : head[rx_pkg::ENT_W-1:rx_pkg::E_PERR];
  wire [2:0] err_view  = blk_mode ? acc_r : head_err;
  wire       rx_src    = full_src ? q_full : ~q_empty;
  wire       wd_flag   = wd_exp_r & watchdog_irq_enable_bit;
  wire [3:0] interrupt_status_word = {counter_ready_status_bit,
                                      break_change_status_bit,
                                      wd_flag, rx_src};
  wire [8:0] receiver_status_word  = {to_mode_r, rx_en_r, wd_exp_r, err_view,
                                      overrun_error_bit, q_full, ~q_empty};

  assign rx_char_waiting_flag  = ~q_empty;
  assign queue_full_flag       = q_full;
  assign request_to_send_out_n = rts_n_r;
  assign irq = |(interrupt_status_word & interrupt_mask_word);

  // read data mux, captured in the setup cycle
  wire [31:0] rd_mux =
      hit_mode ? {27'h000_0000, mode_r} :
      hit_stat ? {23'h00_0000, receiver_status_word} :
      hit_data ? {21'h00_0000, head} :
      hit_irqs ? {28'h000_0000, interrupt_status_word} :
      hit_irqm ? {28'h000_0000, interrupt_mask_word} :
      hit_phi  ? {24'h00_0000, timer_preset_high} :
      hit_plo  ? {24'h00_0000, timer_preset_low} :
      hit_cnt  ? {16'h0000, ct_value} : 32'h0000_0000;

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r              <= rx_pkg::MODE_RST;
      interrupt_mask_word <= rx_pkg::IRQM_RST;
      timer_preset_high   <= 8'h00;
      timer_preset_low    <= 8'h00;
      prdata_r            <= 32'h0000_0000;
    end else begin
      if (wr && hit_mode) mode_r <= pwdata[rx_pkg::MODE_W-1:0];
      if (wr && hit_irqm) interrupt_mask_word <= pwdata[rx_pkg::IRQ_W-1:0];
      if (wr && hit_phi) timer_preset_high <= pwdata[7:0];
      if (wr && hit_plo) timer_preset_low <= pwdata[7:0];
      if (setup && !pwrite) prdata_r <= rd_mux;
    end
  end

  // receiver enable; reset leaves it disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_en_r <= 1'b0;
    else if (c_dis || c_rst) rx_en_r <= 1'b0;
    else if (c_en) rx_en_r <= 1'b1;
  end

  // holder for a completed character that found the queue full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_v_r <= 1'b0;
      hold_r   <= '0;
    end else if (c_rst || !rx_en_r) begin
      hold_v_r <= 1'b0;
    end else if (new_ok && (q_full || hold_v_r)) begin
      hold_v_r <= 1'b1;
      hold_r   <= new_ent;
    end else if (start_det && hold_v_r) begin
      hold_v_r <= 1'b0;
    end else if (push_hold) begin
      hold_v_r <= 1'b0;
    end
  end

  // overrun, block errors and break change; a set beats a clear
  wire ovr_set = rx_en_r & start_det & hold_v_r;
  wire brk_set = push & (q_din[rx_pkg::ENT_W-1] != brk_last_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error_bit       <= 1'b0;
      acc_r                   <= 3'h0;
      break_change_status_bit <= 1'b0;
      brk_last_r              <= 1'b0;
    end else begin
      overrun_error_bit <= ovr_set | (overrun_error_bit & ~(c_err | c_rst));
      acc_r <= head_err | (acc_r & {3{~(c_err | c_rst)}});
      break_change_status_bit <= brk_set
          | (break_change_status_bit & ~(c_brk | c_rst));
      if (c_rst) brk_last_r <= 1'b0;
      else if (push) brk_last_r <= q_din[rx_pkg::ENT_W-1];
    end
  end

  // automatic request-to-send flow control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rts_n_r <= 1'b0;
    else if (c_rst) rts_n_r <= 1'b0;
    else if (flow_en && rx_en_r && start_det && q_full) rts_n_r <= 1'b1;
    else if (!q_full || !flow_en) rts_n_r <= 1'b0;
  end

  // watchdog on unread data, counted in bit times
  wire wd_restart = push | pop | c_rst | q_empty;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_r <= '0;
      wd_exp_r <= 1'b0;
    end else if (wd_restart) begin
      wd_cnt_r <= '0;
      wd_exp_r <= 1'b0;
    end else if (bit_tick && !wd_exp_r) begin
      wd_cnt_r <= wd_cnt_r + 7'h01;
      if (wd_cnt_r + 7'h01 == rx_pkg::WD_BIT_TIMES) wd_exp_r <= 1'b1;
    end
  end

  // time-out mode and counter ready flag
  wire ctr_clr = ct_restart | c_to_on | (c_stop & ~to_mode_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_mode_r                <= 1'b0;
      counter_ready_status_bit <= 1'b0;
    end else begin
      if (c_to_on) to_mode_r <= 1'b1;
      else if (c_to_off) to_mode_r <= 1'b0;
      counter_ready_status_bit <= ct_done
          | (counter_ready_status_bit & ~ctr_clr);
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_wait_flag;
    push && q_empty && !c_rst |=> rx_char_waiting_flag;
  endproperty
  a_wait_flag: assert property (p_wait_flag)
    else $error("waiting flag missing after push");

  property p_full_depth;
    !depth16 && q_count == 5'h08 |-> queue_full_flag;
  endproperty
  a_full_depth: assert property (p_full_depth)
    else $error("full flag wrong for depth eight");

  property p_pop_one;
    pop && !push && !c_rst |=> q_count == $past(q_count) - 5'h01;
  endproperty
  a_pop_one: assert property (p_pop_one)
    else $error("data read did not free one slot");

  property p_stat_quiet;
    rd && hit_stat && !push && !c_rst |=> q_count == $past(q_count);
  endproperty
  a_stat_quiet: assert property (p_stat_quiet)
    else $error("status read moved the queue");

  property p_overrun;
    ovr_set |=> overrun_error_bit && !hold_v_r;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged at new start");

  property p_rts_high;
    flow_en && rx_en_r && start_det && q_full && !c_rst
      |=> request_to_send_out_n;
  endproperty
  a_rts_high: assert property (p_rts_high)
    else $error("rts not negated on full queue");

  property p_no_accept;
    !rx_en_r && !hold_v_r |=> q_count <= $past(q_count);
  endproperty
  a_no_accept: assert property (p_no_accept)
    else $error("disabled receiver accepted a character");

  property p_wd_restart;
    push ##1 (!push && !pop) [*3] |-> wd_cnt_r <= 7'h03;
  endproperty
  a_wd_restart: assert property (p_wd_restart)
    else $error("watchdog not restarted by push");

  property p_to_on;
    c_to_on && !ct_done |=> !counter_ready_status_bit && !ct_running;
  endproperty
  a_to_on: assert property (p_to_on)
    else $error("time-out on left counter ready or running");

  property p_ct_restart;
    ct_restart && !c_to_off ##1 !c_start [*1] |-> !ct_running;
  endproperty
  a_ct_restart: assert property (p_ct_restart)
    else $error("timer not halted after push");

  property p_char_clears;
    counter_ready_status_bit && ct_restart && !ct_done
      |=> !counter_ready_status_bit;
  endproperty
  a_char_clears: assert property (p_char_clears)
    else $error("character did not clear counter ready");

  cover property (ovr_set);
  cover property (to_mode_r && ct_done);
  cover property (depth16 && queue_full_flag);
  cover property (wd_flag && irq);
endmodule

// *** testbench/rx_line_model.sv ***
`timescale 1ns/1ps
module rx_line_model (
  // clock
  input  wire logic pclk,
  // sampler strobes and character
  output logic       start_det,
  output logic       char_done,
  output logic [7:0] char_data,
  output logic       char_perr,
  output logic       char_ferr,
  output logic       char_brk,
  // bit time and timer clock pulses
  output logic       bit_tick,
  output logic       ct_tick
);
  logic [1:0] div_r;
  // idle levels at time zero
  initial begin
    start_det = 1'b0;
    char_done = 1'b0;
    char_data = 8'h00;
    {char_brk, char_ferr, char_perr} = 3'h0;
    bit_tick  = 1'b0;
    ct_tick   = 1'b0;
    div_r     = 2'h0;
  end
  // bit time every 4 clocks, timer clock every 2
  always @(posedge pclk) begin
    div_r    <= div_r + 2'h1;
    bit_tick <= (div_r == 2'h3);
    ct_tick  <= div_r[0];
  end
  // one character; off the strobe the data lines show the inverse
  task automatic send(input logic [7:0] d, input logic [2:0] e);
    @(posedge pclk);
    start_det <= 1'b1;
    @(posedge pclk);
    start_det <= 1'b0;
    repeat (3) @(posedge pclk);
    char_done <= 1'b1;
    char_data <= d;
    {char_brk, char_ferr, char_perr} <= e;
    @(posedge pclk);
    char_done <= 1'b0;
    char_data <= ~d;
    {char_brk, char_ferr, char_perr} <= ~e;
    @(posedge pclk);
    #1;
  endtask
  // start bit of a character that never completes
  task automatic start_only();
    @(posedge pclk);
    start_det <= 1'b1;
    @(posedge pclk);
    start_det <= 1'b0;
    @(posedge pclk);
    #1;
  endtask
endmodule

// *** testbench/tb_uart_rx_fifo_timeout.sv ***
`timescale 1ns/1ps
module tb_uart_rx_fifo_timeout;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, v;
  logic        pready, pslverr, serr, rts_n, waiting, full, irq;
  logic        start_det, char_done, char_perr, char_ferr, char_brk;
  logic        bit_tick, ct_tick;
  logic [7:0]  char_data;
  int          mismatches = 0;
  int          comparisons = 0;
  int          n;
  // clock and instances
  always #5 pclk = ~pclk;
  uart_rx_fifo_timeout dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .start_det, .char_done,
    .char_data, .char_perr, .char_ferr, .char_brk, .bit_tick, .ct_tick,
    .request_to_send_out_n(rts_n), .rx_char_waiting_flag(waiting),
    .queue_full_flag(full), .irq(irq));
  rx_line_model line (.pclk, .start_det, .char_done, .char_data,
    .char_perr, .char_ferr, .char_brk, .bit_tick, .ct_tick);
  // final report and verdict
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic flag(input string nm, input logic got, exp);
    chk(nm, {31'h0, got}, {31'h0, exp});
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    v = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, v, e);
  endtask
  // bounded wait for the interrupt line
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (irq !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    flag("reset flags", waiting | full | irq | rts_n, 1'b0);
    rd(rx_pkg::OFF_MODE, 32'h0, "mode reset");
    rd(8'h40, 32'h0, "unmapped");
    flag("slverr", serr, 1'b1);
    // depth 8 then 16: full, flow control, overrun, receiver reset
    for (int k = 0; k < 2; k++) begin
      wr(rx_pkg::OFF_MODE, k ? 32'h18 : 32'h08);
      wr(rx_pkg::OFF_CMD, 32'h10);
      for (int i = 0; i < (k ? 16 : 8); i++) begin
        flag("full early", full, 1'b0);
        line.send(i[7:0], 3'h0);
      end
      flag("full", full, 1'b1);
      line.send(8'hee, 3'h0);
      flag("rts held", rts_n, 1'b1);
      line.start_only();
      rd(rx_pkg::OFF_STAT, 32'h87, "overrun");
      flag("full kept", full, 1'b1);
      rd(rx_pkg::OFF_DATA, 32'h0, "oldest");
      flag("rts freed", rts_n, 1'b0);
      wr(rx_pkg::OFF_CMD, 32'h30);
      flag("rx reset", waiting, 1'b0);
      rd(rx_pkg::OFF_STAT, 32'h0, "reset stat");
    end
    // per character error bits, break and block mode
    wr(rx_pkg::OFF_MODE, 32'h0);
    wr(rx_pkg::OFF_CMD, 32'h10);
    line.send(8'h41, 3'h1);
    line.send(8'h42, 3'h2);
    line.send(8'h55, 3'h4);
    rd(rx_pkg::OFF_STAT, 32'h89, "perr stat");
    rd(rx_pkg::OFF_DATA, 32'h141, "perr data");
    rd(rx_pkg::OFF_STAT, 32'h91, "ferr stat");
    rd(rx_pkg::OFF_DATA, 32'h242, "ferr data");
    rd(rx_pkg::OFF_STAT, 32'ha1, "brk stat");
    rd(rx_pkg::OFF_DATA, 32'h400, "brk data");
    wr(rx_pkg::OFF_MODE, 32'h1);
    wr(rx_pkg::OFF_CMD, 32'h40);
    line.send(8'h01, 3'h1);
    line.send(8'h02, 3'h2);
    rd(rx_pkg::OFF_DATA, 32'h101, "blk 1");
    rd(rx_pkg::OFF_DATA, 32'h202, "blk 2");
    rd(rx_pkg::OFF_STAT, 32'h98, "block or");
    wr(rx_pkg::OFF_CMD, 32'h40);
    rd(rx_pkg::OFF_STAT, 32'h80, "err reset");
    // disabled receiver keeps data and interrupt, takes nothing new
    wr(rx_pkg::OFF_MODE, 32'h0);
    wr(rx_pkg::OFF_IRQM, 32'h1);
    line.send(8'h61, 3'h0);
    wr(rx_pkg::OFF_CMD, 32'h20);
    line.send(8'h62, 3'h0);
    rd(rx_pkg::OFF_STAT, 32'h1, "disabled");
    flag("irq wait src", irq, 1'b1);
    wr(rx_pkg::OFF_MODE, 32'h4);
    flag("irq full src", irq, 1'b0);
    rd(rx_pkg::OFF_DATA, 32'h61, "disabled rd");
    flag("none taken", waiting, 1'b0);
    // watchdog on unread data
    wr(rx_pkg::OFF_MODE, 32'h2);
    wr(rx_pkg::OFF_IRQM, 32'h2);
    wr(rx_pkg::OFF_CMD, 32'h10);
    line.send(8'h70, 3'h0);
    flag("wd early", irq, 1'b0);
    wait_irq(400);
    flag("wd time", n >= 240 && n <= 270, 1'b1);
    rd(rx_pkg::OFF_IRQS, 32'h7, "wd irq stat");
    wr(rx_pkg::OFF_CMD, 32'h50);
    rd(rx_pkg::OFF_IRQS, 32'h3, "brk change reset");
    rd(rx_pkg::OFF_DATA, 32'h70, "wd data");
    // receive time-out mode; preset well above one character time
    wr(rx_pkg::OFF_MODE, 32'h0);
    wr(rx_pkg::OFF_PLO, 32'h10);
    wr(rx_pkg::OFF_PHI, 32'h0);
    wr(rx_pkg::OFF_IRQM, 32'h8);
    wr(rx_pkg::OFF_CMD, 32'ha0);
    rd(rx_pkg::OFF_STAT, 32'h180, "to on");
    flag("to idle", irq, 1'b0);
    line.send(8'h33, 3'h0);
    wait_irq(200);
    flag("to time", n >= 28 && n <= 48, 1'b1);
    wr(rx_pkg::OFF_CMD, 32'h70);
    rd(rx_pkg::OFF_IRQS, 32'h9, "stop ignored");
    line.send(8'h34, 3'h0);
    rd(rx_pkg::OFF_IRQS, 32'h1, "to cleared");
    flag("to irq gone", irq, 1'b0);
    wr(rx_pkg::OFF_CMD, 32'hc0);
    rd(rx_pkg::OFF_STAT, 32'h81, "to off");
    // plain counter mode: start loads preset, stop freezes it
    wr(rx_pkg::OFF_CMD, 32'h60);
    wr(rx_pkg::OFF_CMD, 32'h70);
    apb(1'b0, rx_pkg::OFF_CNT, 32'h0);
    flag("ct stopped", v == 32'he || v == 32'hf, 1'b1);
    wrap_up();
  end
endmodule
